// ===== shared/port_b_regs.svh
// Register map, field positions, reset values for the port B pin block
`ifndef PORT_B_REGS_SVH
`define PORT_B_REGS_SVH
`define DIR_INDEX 20'hE_E00A
`define DATA_INDEX 20'hF_FFDA
`define DIR_ADDR ({2'b00, `DIR_INDEX} << 2)
`define DATA_ADDR ({2'b00, `DATA_INDEX} << 2)
`define CTRL_ADDR 22'h00_0000
`define ADDR_W 22
`define DIR_RESET 8'h00
`define DATA_RESET 8'h00
`define DIR_READ 8'hFF
`define CTRL_RESET 13'h0000
`define F_PE13 0
`define F_PE14 1
`define F_PE15 2
`define F_SMART 3
`define F_RX_EN 4
`define F_TX_EN 5
`define F_CLK_EN_LO 6
`define F_CLK_EN_HI 7
`define F_CLKD 8
`define F_AREA_LO 9
`define F_AREA_HI 11
`define F_COL_SEL 12
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`endif

// ===== shared/port_b_pkg.sv
// Types shared by the port B pin block
package port_b_pkg;
  typedef struct packed {
    logic column_strobe_select;
    logic [2:0] dram_area_select;
    logic clocked_select;
    logic clock_enable_high;
    logic clock_enable_low;
    logic transmit_enable;
    logic receive_enable;
    logic smart_card_select;
    logic pattern_enable_15;
    logic pattern_enable_14;
    logic pattern_enable_13;
  } func_ctrl_t;
  typedef struct packed {
    logic [2:0] pattern_data;
    logic serial_transmit_out;
    logic transmit_drive;
    logic serial_clock_pin;
    logic lower_column_strobe;
    logic [1:0] chip_select_n;
    logic [1:0] row_strobe_n;
  } unit_sig_t;
endpackage

// ===== design/port_b_pin_control.sv
// Port B pin control: direction, output data, pin function select, AXI4-Lite
// Functional notes
// [R1] Eight pins, each general input or output unless another function claims it.
// [R2] Reset or hardware standby leaves every pin an input.
// [R3] Direction bit 1 makes its pin an output, 0 an input.
// [R4] Direction register is write-only; reads return all ones.
// [R5] Direction clears on reset and hardware standby, held in software standby.
// [R6] Output pins keep driving through software standby.
// [R7] General output pins drive the output data bit.
// [R8] Data read gives stored bit for outputs, pin level for inputs.
// [R9] Output data clears on reset and hardware standby, held in software standby.
// [R10] Software sets direction bit as well as pattern enable for pattern output.
// [R11] With DRAM in areas 2 to 5, area 4/5 selects become row strobes.
// [R12] Bit 7: general or pattern 15, else serial receive input.
// [R13] Bit 6: general or pattern 14, else serial transmit output.
// [R14] Smart-card transmit on bit 6 alternates driven and high impedance.
// [R15] Bit 5: general or pattern 13, else serial clock, input with high enable.
// [R16] Bit 5 drives lower column strobe when DRAM settings select it, overriding all.
// [R17] Register writes reach the pins one cycle later, no other side effect.
//
// Design decision made here: the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "port_b_regs.svh"
module port_b_pin_control
  import port_b_pkg::*;
#(
  parameter int PORT_WIDTH = 8
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic resetn_in,
  // Standby modes
  input wire logic hw_standby_in,
  input wire logic sw_standby_in,
  // AXI4-Lite slave
  input wire logic [`ADDR_W-1:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [`ADDR_W-1:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  // Other on-chip units
  input wire unit_sig_t unit_in,
  output logic serial_receive_in_out,
  output logic serial_clock_in_out,
  output logic [1:0] area_strobe_n_out,
  // Port pins
  input wire logic [PORT_WIDTH-1:0] pin_in,
  output logic [PORT_WIDTH-1:0] pin_out,
  output logic [PORT_WIDTH-1:0] pin_oe_out
);

  if (PORT_WIDTH != 8) begin : g_width_check
    $error("port_b_pin_control serves exactly eight pins");
  end

  // Register file
  logic [7:0] dir_reg, dir_next;
  logic [7:0] data_reg, data_next;
  func_ctrl_t ctrl_reg, ctrl_next;
  // Bus slave state
  logic aw_held_reg, aw_held_next;
  logic w_held_reg, w_held_next;
  logic [`ADDR_W-1:0] aw_addr_reg, aw_addr_next;
  logic [7:0] w_byte_reg, w_byte_next;
  logic [4:0] ctrl_hi_reg, ctrl_hi_next;
  logic ctrl_hi_lane_reg, ctrl_hi_lane_next;
  logic w_lane_reg, w_lane_next;
  logic bvalid_reg, bvalid_next;
  logic [1:0] bresp_reg, bresp_next;
  logic rvalid_reg, rvalid_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [1:0] rresp_reg, rresp_next;
  // Pin state
  logic [7:0] pin_out_reg, pin_out_next;
  logic [7:0] pin_oe_reg, pin_oe_next;
  logic [1:0] area_reg, area_next;
  logic rx_reg, rx_next;
  logic sck_reg, sck_next;

  logic do_write;
  logic dram_mapped;
  logic col_strobe_active;
  logic [7:0] port_read;

  assign do_write = aw_held_reg && w_held_reg && !bvalid_reg;
  assign dram_mapped = ctrl_reg.dram_area_select != 3'b000;
  assign col_strobe_active = dram_mapped && ctrl_reg.column_strobe_select;
  assign port_read = (dir_reg & data_reg) | (~dir_reg & pin_in); // see [R8]

  // Write channel: address and data taken in either order
  always_comb begin
    aw_held_next = aw_held_reg;
    w_held_next = w_held_reg;
    aw_addr_next = aw_addr_reg;
    w_byte_next = w_byte_reg;
    w_lane_next = w_lane_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    dir_next = dir_reg;
    data_next = data_reg;
    ctrl_next = ctrl_reg;
    if (s_axi_awvalid_in && !aw_held_reg) begin
      aw_held_next = 1'b1;
      aw_addr_next = s_axi_awaddr_in;
    end
    if (s_axi_wvalid_in && !w_held_reg) begin
      w_held_next = 1'b1;
      w_byte_next = s_axi_wdata_in[7:0];
      w_lane_next = s_axi_wstrb_in[0];
    end
    if (do_write) begin
      aw_held_next = 1'b0;
      w_held_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = `RESP_OKAY;
      unique case (aw_addr_reg)
        `DIR_ADDR: if (w_lane_reg) dir_next = w_byte_reg; // see [R3] [R17]
        `DATA_ADDR: if (w_lane_reg) data_next = w_byte_reg; // see [R17]
        `CTRL_ADDR: begin
          if (w_lane_reg) ctrl_next[7:0] = w_byte_reg;
          if (ctrl_hi_lane_reg) ctrl_next[12:8] = ctrl_hi_reg;
        end
        default: bresp_next = `RESP_SLVERR;
      endcase
    end
    if (bvalid_reg && s_axi_bready_in) begin
      bvalid_next = 1'b0;
    end
    if (hw_standby_in) begin
      dir_next = `DIR_RESET; // see [R5]
      data_next = `DATA_RESET; // see [R9]
    end
  end

  // Upper control byte rides on lane 1, captured with the data word
  always_comb begin
    ctrl_hi_next = ctrl_hi_reg;
    ctrl_hi_lane_next = ctrl_hi_lane_reg;
    if (s_axi_wvalid_in && !w_held_reg) begin
      ctrl_hi_next = s_axi_wdata_in[12:8];
      ctrl_hi_lane_next = s_axi_wstrb_in[1];
    end
  end

  // Read channel: one answer a cycle after the address is taken
  always_comb begin
    rvalid_next = rvalid_reg;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    if (s_axi_arvalid_in && !rvalid_reg) begin
      rvalid_next = 1'b1;
      rresp_next = `RESP_OKAY;
      unique case (s_axi_araddr_in)
        `DIR_ADDR: rdata_next = {24'h00_0000, `DIR_READ}; // see [R4]
        `DATA_ADDR: rdata_next = {24'h00_0000, port_read}; // see [R8]
        `CTRL_ADDR: rdata_next = {19'h0_0000, ctrl_reg};
        default: begin
          rdata_next = 32'h0000_0000;
          rresp_next = `RESP_SLVERR;
        end
      endcase
    end else if (rvalid_reg && s_axi_rready_in) begin
      rvalid_next = 1'b0;
    end
  end

  // Pin function select, computed from the registers of the previous cycle
  always_comb begin
    pin_oe_next = dir_reg; // see [R1] [R3]
    pin_out_next = data_reg; // see [R7]
    // Bit 7: serial receive claims the pin whenever receive or smart card is on
    if (ctrl_reg.smart_card_select || ctrl_reg.receive_enable) begin
      pin_oe_next[7] = 1'b0; // see [R12]
    end else if (ctrl_reg.pattern_enable_15) begin
      pin_out_next[7] = unit_in.pattern_data[2]; // see [R12]
    end
    // Bit 6
    if (ctrl_reg.smart_card_select || ctrl_reg.transmit_enable) begin
      pin_out_next[6] = unit_in.serial_transmit_out; // see [R13]
      pin_oe_next[6] = ctrl_reg.smart_card_select ? unit_in.transmit_drive : 1'b1; // see [R14]
    end else if (ctrl_reg.pattern_enable_14) begin
      pin_out_next[6] = unit_in.pattern_data[1]; // see [R13]
    end
    // Bit 5: column strobe wins over every other setting
    if (col_strobe_active) begin
      pin_oe_next[5] = 1'b1; // see [R16]
      pin_out_next[5] = unit_in.lower_column_strobe;
    end else if (ctrl_reg.clock_enable_high || ctrl_reg.clocked_select
                 || ctrl_reg.clock_enable_low) begin
      pin_oe_next[5] = !ctrl_reg.clock_enable_high; // see [R15]
      pin_out_next[5] = unit_in.serial_clock_pin;
    end else if (ctrl_reg.pattern_enable_13) begin
      pin_out_next[5] = unit_in.pattern_data[0]; // see [R15]
    end
    if (hw_standby_in) begin
      pin_oe_next = 8'h00; // see [R2]
      pin_out_next = 8'h00;
    end else if (sw_standby_in) begin
      // Pins freeze so outputs keep their level while the chip sleeps
      pin_oe_next = pin_oe_reg; // see [R6]
      pin_out_next = pin_out_reg;
    end
  end

  always_comb begin
    area_next = dram_mapped ? unit_in.row_strobe_n : unit_in.chip_select_n; // see [R11]
    rx_next = pin_in[7];
    sck_next = pin_in[5];
  end

  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      dir_reg <= `DIR_RESET; // see [R5]
      data_reg <= `DATA_RESET; // see [R9]
      ctrl_reg <= `CTRL_RESET;
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      aw_addr_reg <= '0;
      w_byte_reg <= 8'h00;
      w_lane_reg <= 1'b0;
      ctrl_hi_reg <= 5'h00;
      ctrl_hi_lane_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= `RESP_OKAY;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= `RESP_OKAY;
      pin_out_reg <= 8'h00;
      pin_oe_reg <= 8'h00; // see [R2]
      area_reg <= 2'b11;
      rx_reg <= 1'b0;
      sck_reg <= 1'b0;
    end else begin
      dir_reg <= dir_next;
      data_reg <= data_next;
      ctrl_reg <= ctrl_next;
      aw_held_reg <= aw_held_next;
      w_held_reg <= w_held_next;
      aw_addr_reg <= aw_addr_next;
      w_byte_reg <= w_byte_next;
      w_lane_reg <= w_lane_next;
      ctrl_hi_reg <= ctrl_hi_next;
      ctrl_hi_lane_reg <= ctrl_hi_lane_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
      pin_out_reg <= pin_out_next;
      pin_oe_reg <= pin_oe_next;
      area_reg <= area_next;
      rx_reg <= rx_next;
      sck_reg <= sck_next;
    end
  end

  assign s_axi_awready_out = !aw_held_reg;
  assign s_axi_wready_out = !w_held_reg;
  assign s_axi_bvalid_out = bvalid_reg;
  assign s_axi_bresp_out = bresp_reg;
  assign s_axi_arready_out = !rvalid_reg;
  assign s_axi_rvalid_out = rvalid_reg;
  assign s_axi_rdata_out = rdata_reg;
  assign s_axi_rresp_out = rresp_reg;
  assign pin_out = pin_out_reg;
  assign pin_oe_out = pin_oe_reg;
  assign area_strobe_n_out = area_reg;
  assign serial_receive_in_out = rx_reg;
  assign serial_clock_in_out = sck_reg;

  logic plain_mode;
  assign plain_mode = !hw_standby_in && !sw_standby_in;

  a_hw_standby_inputs: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    hw_standby_in |=> pin_oe_out == 8'h00 && dir_reg == 8'h00 && data_reg == 8'h00) // see [R2]
    else $error("hardware standby left a pin driven or a register set");
  a_dir_read_ones: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    s_axi_arvalid_in && s_axi_arready_out && s_axi_araddr_in == `DIR_ADDR
    |=> s_axi_rvalid_out && s_axi_rdata_out == 32'h0000_00FF) // see [R4]
    else $error("direction read did not return all ones");
  a_data_read_mix: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    s_axi_arvalid_in && s_axi_arready_out && s_axi_araddr_in == `DATA_ADDR
    |=> s_axi_rdata_out[7:0] == (($past(dir_reg) & $past(data_reg))
    | (~$past(dir_reg) & $past(pin_in)))) // see [R8]
    else $error("port read mixed data and pin levels wrongly");
  a_low_pins_follow: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    plain_mode |=> pin_oe_out[4:0] == $past(dir_reg[4:0])
    && pin_out[4:0] == $past(data_reg[4:0])) // see [R3]
    else $error("general pin did not follow direction and data");
  a_sw_standby_hold: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    sw_standby_in && !hw_standby_in |=> $stable(pin_oe_out) && $stable(pin_out)
    && $stable(dir_reg)) // see [R6]
    else $error("pins changed during software standby");
  a_rx_input: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    plain_mode && (ctrl_reg.smart_card_select || ctrl_reg.receive_enable)
    |=> !pin_oe_out[7]) // see [R12]
    else $error("receive pin was driven");
  a_tx_driven: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    plain_mode && ctrl_reg.transmit_enable && !ctrl_reg.smart_card_select
    |=> pin_oe_out[6] && pin_out[6] == $past(unit_in.serial_transmit_out)) // see [R13]
    else $error("transmit pin not driven with serial data");
  a_col_strobe_wins: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    plain_mode && col_strobe_active
    |=> pin_oe_out[5] && pin_out[5] == $past(unit_in.lower_column_strobe)) // see [R16]
    else $error("column strobe did not take bit 5");
  a_row_strobe: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    dram_mapped |=> area_strobe_n_out == $past(unit_in.row_strobe_n)) // see [R11]
    else $error("area 4/5 select not replaced by row strobe");
  a_write_answer: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    do_write && aw_addr_reg == `DIR_ADDR && w_lane_reg && !hw_standby_in
    |=> s_axi_bvalid_out && dir_reg == $past(w_byte_reg)) // see [R17]
    else $error("direction write not applied and answered in one cycle");

endmodule

// ===== dv/port_b_pins_model.sv
// External circuitry on the port pins: pull-ups plus an optional driver per pin
`timescale 1ns/1ps
module port_b_pins_model #(
  parameter int WIDTH = 8
) (
  // Device side
  input wire logic [WIDTH-1:0] pin_out_in,
  input wire logic [WIDTH-1:0] pin_oe_in,
  // Bench control
  input wire logic [WIDTH-1:0] ext_level_in,
  input wire logic [WIDTH-1:0] ext_drive_in,
  // Resolved levels
  output logic [WIDTH-1:0] pin_level_out
);
  // External drivers are resistive, so the device wins; an idle pin floats up
  always_comb begin
    for (int i = 0; i < WIDTH; i++) begin
      if (pin_oe_in[i]) begin
        pin_level_out[i] = pin_out_in[i];
      end else if (ext_drive_in[i]) begin
        pin_level_out[i] = ext_level_in[i];
      end else begin
        pin_level_out[i] = 1'b1;
      end
    end
  end
endmodule

// ===== dv/port_b_pin_control_test.sv
// Self-checking bench for the port B pin block
`timescale 1ns/1ps
`include "port_b_regs.svh"
module port_b_pin_control_test
  import port_b_pkg::*;
;
  logic clk_sys_in = 1'b0;
  logic resetn_in = 1'b0;
  logic hw_sb = 1'b0;
  logic sw_sb = 1'b0;
  logic [`ADDR_W-1:0] awaddr = '0;
  logic [`ADDR_W-1:0] araddr = '0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic [31:0] wdata = '0;
  logic [3:0] wstrb = 4'hF;
  unit_sig_t unit = '0;
  logic [7:0] ext_lvl = 8'h00;
  logic [7:0] ext_drv = 8'h00;
  logic awready, wready, bvalid, arready, rvalid, rx_in, sck_in;
  logic [1:0] bresp, rresp, area_n, resp;
  logic [31:0] rdata, rd;
  logic [7:0] pin_lvl, pin_out, pin_oe;
  int miscompares = 0;
  int samples_checked = 0;

  always #4 clk_sys_in = ~clk_sys_in;

  port_b_pin_control #(.PORT_WIDTH(8)) i_port_b_pin_control (
    .clk_sys_in(clk_sys_in), .resetn_in(resetn_in),
    .hw_standby_in(hw_sb), .sw_standby_in(sw_sb),
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
    .s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid),
    .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
    .s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
    .s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
    .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready), .unit_in(unit),
    .serial_receive_in_out(rx_in), .serial_clock_in_out(sck_in),
    .area_strobe_n_out(area_n), .pin_in(pin_lvl), .pin_out(pin_out), .pin_oe_out(pin_oe)
  );

  port_b_pins_model #(.WIDTH(8)) i_port_b_pins_model (
    .pin_out_in(pin_out), .pin_oe_in(pin_oe), .ext_level_in(ext_lvl),
    .ext_drive_in(ext_drv), .pin_level_out(pin_lvl)
  );

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic end_of_test();
    if (miscompares == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic hang();
    chk(32'h0000_0000, 32'h0000_0001);
    end_of_test();
  endtask

  // Registered outputs have taken the last edge's inputs by the next falling edge
  task automatic settle();
    @(posedge clk_sys_in);
    @(negedge clk_sys_in);
  endtask

  task automatic axi_write(input logic [`ADDR_W-1:0] a, input logic [31:0] d);
    bit done;
    done = 1'b0;
    @(posedge clk_sys_in);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int n = 0; n < 50 && !done; n++) begin
      @(posedge clk_sys_in);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        resp = bresp;
        bready <= 1'b0;
        done = 1'b1;
      end
    end
    if (!done) hang();
  endtask

  task automatic axi_read(input logic [`ADDR_W-1:0] a);
    bit done;
    done = 1'b0;
    @(posedge clk_sys_in);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int n = 0; n < 50 && !done; n++) begin
      @(posedge clk_sys_in);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        rd = rdata;
        resp = rresp;
        rready <= 1'b0;
        done = 1'b1;
      end
    end
    if (!done) hang();
  endtask

  task automatic t_reset();
    @(posedge clk_sys_in);
    ext_drv <= 8'hFF;
    ext_lvl <= 8'h5A;
    @(negedge clk_sys_in);
    chk(pin_oe, 8'h00);
    axi_read(`DIR_ADDR);
    chk(rd, 32'h0000_00FF);
    axi_read(`DATA_ADDR);
    chk(rd, 32'h0000_005A);
  endtask

  task automatic t_gpio();
    axi_write(`DIR_ADDR, 32'h0000_00F0);
    chk(resp, `RESP_OKAY);
    axi_write(`DATA_ADDR, 32'h0000_005A);
    @(negedge clk_sys_in);
    chk(pin_oe, 8'hF0);
    chk(pin_out & 8'hF0, 8'h50);
    @(posedge clk_sys_in);
    ext_lvl <= 8'h3C;
    axi_read(`DATA_ADDR);
    chk(rd, 32'h0000_005C);
    axi_read(`DIR_ADDR);
    chk(rd, 32'h0000_00FF);
  endtask

  task automatic t_unmapped();
    axi_write(22'h00_0010, 32'h0000_00FF);
    chk(resp, `RESP_SLVERR);
    axi_read(22'h00_0010);
    chk(rd, 32'h0000_0000);
    chk(resp, `RESP_SLVERR);
    // A write with lane 0 off must leave the direction untouched
    @(posedge clk_sys_in);
    wstrb <= 4'h0;
    axi_write(`DIR_ADDR, 32'h0000_00FF);
    @(posedge clk_sys_in);
    wstrb <= 4'hF;
    @(negedge clk_sys_in);
    chk(pin_oe, 8'hF0);
  endtask

  task automatic t_standby();
    // Pattern output needs the direction bit as well as the enable
    axi_write(`DIR_ADDR, 32'h0000_0020);
    axi_write(`CTRL_ADDR, 32'h0000_0001);
    @(posedge clk_sys_in);
    unit.pattern_data <= 3'h1;
    settle();
    chk(pin_out[5], 1'b1);
    @(posedge clk_sys_in);
    sw_sb <= 1'b1;
    @(posedge clk_sys_in);
    unit.pattern_data <= 3'h0;
    settle();
    chk({pin_oe[5], pin_out[5]}, 2'h3);
    @(posedge clk_sys_in);
    sw_sb <= 1'b0;
    settle();
    settle();
    chk({pin_oe[5], pin_out[5]}, 2'h2);
    @(posedge clk_sys_in);
    hw_sb <= 1'b1;
    settle();
    chk(pin_oe, 8'h00);
    @(posedge clk_sys_in);
    hw_sb <= 1'b0;
    settle();
    // Pattern enable is still on, but the cleared direction keeps bit 5 an input
    chk(pin_oe, 8'h00);
    axi_write(`CTRL_ADDR, 32'h0000_0000);
    axi_write(`DIR_ADDR, 32'h0000_00FF);
    axi_read(`DATA_ADDR);
    chk(rd, 32'h0000_0000);
  endtask

  task automatic t_modes();
    logic [12:0] ctl [10] = '{13'h0000, 13'h0007, 13'h0010, 13'h0008, 13'h0020,
                              13'h0080, 13'h0100, 13'h0040, 13'h1280, 13'h0200};
    logic [2:0] eoe [10] = '{3'h7, 3'h7, 3'h3, 3'h3, 3'h7, 3'h6, 3'h7, 3'h7, 3'h7, 3'h7};
    logic [2:0] eout [10] = '{3'h5, 3'h2, 3'h1, 3'h3, 3'h7, 3'h4, 3'h4, 3'h4, 3'h4, 3'h5};
    axi_write(`DIR_ADDR, 32'h0000_00E0);
    axi_write(`DATA_ADDR, 32'h0000_00A0);
    @(posedge clk_sys_in);
    unit <= '{pattern_data: 3'h2, serial_transmit_out: 1'b1, transmit_drive: 1'b1,
              serial_clock_pin: 1'b0, lower_column_strobe: 1'b0, chip_select_n: 2'h1,
              row_strobe_n: 2'h2};
    ext_drv <= 8'h00;
    foreach (ctl[i]) begin
      axi_write(`CTRL_ADDR, {19'h0_0000, ctl[i]});
      @(negedge clk_sys_in);
      chk(pin_oe[7:5], eoe[i]);
      chk(pin_out[7:5] & eoe[i], eout[i]);
      chk(area_n, (ctl[i][11:9] != 3'h0) ? 2'h2 : 2'h1);
    end
  endtask

  task automatic t_serial();
    axi_write(`CTRL_ADDR, 32'h0000_0090);
    for (int v = 0; v < 2; v++) begin
      @(posedge clk_sys_in);
      ext_drv <= 8'hA0;
      ext_lvl <= v[0] ? 8'hA0 : 8'h00;
      settle();
      chk({rx_in, sck_in, pin_oe[7], pin_oe[5]}, {v[0], v[0], 2'h0});
    end
    axi_write(`CTRL_ADDR, 32'h0000_0008);
    for (int v = 0; v < 2; v++) begin
      @(posedge clk_sys_in);
      unit.transmit_drive <= v[0];
      settle();
      chk(pin_oe[6], v[0]);
    end
  endtask

  initial begin
    repeat (20) @(posedge clk_sys_in);
    resetn_in <= 1'b1;
    t_reset();
    t_gpio();
    t_unmapped();
    t_standby();
    t_modes();
    t_serial();
    end_of_test();
  end
endmodule
